// ---- bench/uart_frame_tx_tb_top.sv ----
// self-checking bench for the serial frame transmitter
`include "uart_tx_params.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("[ERR] %0t got %h want %h", $time, g, e); end end
module uart_frame_tx_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, txd, txd_oe, rxd, xck_in;
  logic        xck_out, xck_oe;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rs;
  int          bad_count, total_checks, gap;
  // ********
  // harness
  // ********
  uart_frame_tx uart_frame_tx_i (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .txd(txd), .txd_oe(txd_oe), .rxd(rxd), .xck_in(xck_in),
    .xck_out(xck_out), .xck_oe(xck_oe));
  uart_peer uart_peer_i (.aclk(aclk), .rxd(rxd), .xck_in(xck_in));
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic hang();
    bad_count++;
    $display("[ERR] %0t wait timed out", $time);
    final_report();
  endtask
  // address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
      if (n > 99) hang();
    end while (!bvalid);
    bready <= 1'b0;
    rs = bresp;
  endtask
  task automatic rdr(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      n++;
      if (n > 99) hang();
    end while (!rvalid);
    rready <= 1'b0;
    rd = rdata;
    rs = rresp;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rdr(a);
    `CHK(rd, e)
  endtask
  task automatic wait_empty();
    int n;
    n = 0;
    do begin
      rdr(`OFF_CSA);
      n++;
      if (n > 99) hang();
    end while (rd[`CSA_TX_BUFFER_EMPTY_FLAG] !== 1'b1);
  endtask
  // samples each bit mid-period; returns in the middle of the last stop bit
  task automatic rx_frame(input logic [8:0] d, input int n, input logic [1:0] pm,
                          input int ns, input int p);
    logic [12:0] f;
    logic        par;
    int          nb;
    // stop bits and unused slots high
    f = 13'h1fff;
    f[0] = 1'b0;
    // xor of data bits, odd inverts
    par = pm[0];
    for (int i = 0; i < n; i++) begin
      f[i + 1] = d[i];
      par ^= d[i];
    end
    nb = n + 1;
    // parity right after the last data bit
    if (pm[1]) begin
      f[nb] = par;
      nb++;
    end
    nb += ns;
    gap = 0;
    do begin
      @(posedge aclk);
      gap++;
      if (gap > 3000) hang();
    end while (txd !== 1'b0);
    repeat (p / 2 - 1) @(posedge aclk);
    for (int k = 0; k < nb; k++) begin
      `CHK(txd, f[k])
      if (k < nb - 1) repeat (p) @(posedge aclk);
    end
  endtask
  // ********
  // scenarios
  // ********
  task automatic t_reset();
    `CHK(txd, 1'b1)
    `CHK(txd_oe, 1'b0)
    `CHK(xck_out, 1'b0)
    `CHK(xck_oe, 1'b0)
    rchk(`OFF_CSA, 32'h20);
    rchk(`OFF_SHARED, 32'h86);
    wr(`OFF_SHARED, 8'h00);
    rchk(`OFF_SHARED, 32'h86);
    wr(8'h14, 8'h55);
    `CHK(rs, `RESP_SLVERR)
    rdr(8'h14);
    `CHK(rs, `RESP_SLVERR)
    $display("reset test done");
  endtask
  // complete flag cleared before each load
  task automatic fmt_run(input logic [7:0] a, b, c, input logic [8:0] d, input int n);
    int p, ns;
    p = c[6] ? 2 : (a[1] ? 8 : 16);
    ns = c[3] ? 2 : 1;
    // rate, format and enables set before any traffic
    // format only rewritten while the line is quiet
    wr(`OFF_CSA, a | 8'h40);
    wr(`OFF_CSB, b);
    wr(`OFF_SHARED, c);
    rchk(`OFF_SHARED, {24'h0, c});
    wait_empty();
    fork
      rx_frame(d, n, c[5:4], ns, p);
      wr(`OFF_DATA, d[7:0]);
    join
    `CHK(txd_oe, 1'b1)
    `CHK(xck_oe, c[6])
    repeat (p) @(posedge aclk);
    rchk(`OFF_CSA, {24'h0, a | 8'h60});
    $display("format %h done", c);
  endtask
  task automatic t_b2b();
    fork
      begin
        rx_frame(9'h081, 8, 2'h0, 1, 16);
        rx_frame(9'h07e, 8, 2'h0, 1, 16);
        `CHK(gap <= 10, 1'b1)
      end
      begin
        wr(`OFF_DATA, 8'h81);
        wait_empty();
        wr(`OFF_DATA, 8'h7e);
        rdr(`OFF_CSA);
        `CHK(rd[`CSA_TX_BUFFER_EMPTY_FLAG], 1'b0)
      end
    join
    $display("back to back test done");
  endtask
  task automatic t_fe();
    wr(`OFF_CSA, 8'h40);
    wr(`OFF_CSB, 8'h18);
    wr(`OFF_SHARED, 8'h8e);
    uart_peer_i.send(9'h0a5, 8, 1'b1, 1'b0, 16);
    rdr(`OFF_CSA);
    `CHK(rd[`CSA_FE], 1'b0)
    uart_peer_i.send(9'h0a5, 8, 1'b0, 1'b1, 16);
    rdr(`OFF_CSA);
    `CHK(rd[`CSA_FE], 1'b1)
    wr(`OFF_SHARED, 8'h84);
    uart_peer_i.send(9'h05a, 7, 1'b1, 1'b0, 16);
    rdr(`OFF_CSA);
    `CHK(rd[`CSA_FE], 1'b0)
    $display("frame error test done");
  endtask
  initial begin
    bad_count = 0;
    total_checks = 0;
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hf;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    fmt_run(8'h00, 8'h08, 8'h86, 9'h0a5, 8);
    t_b2b();
    fmt_run(8'h00, 8'h08, 8'ha0, 9'h1f3, 5);
    fmt_run(8'h00, 8'h08, 8'hbc, 9'h0c5, 7);
    fmt_run(8'h02, 8'h08, 8'haa, 9'h02d, 6);
    fmt_run(8'h00, 8'h0d, 8'hb6, 9'h1a5, 9);
    fmt_run(8'h00, 8'h0c, 8'h86, 9'h0a5, 9);
    fmt_run(8'h00, 8'h08, 8'hc6, 9'h03c, 8);
    t_fe();
    final_report();
  end
endmodule // uart_frame_tx_tb_top

// ---- bench/uart_peer.sv ----
// remote serial peer that drives the receive line
module uart_peer (
  input  wire logic aclk,
  output logic      rxd,
  output logic      xck_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // ********
  // peer line
  // ********
  // idle line high
  initial begin
    rxd    = 1'b1;
    xck_in = 1'b0;
  end
  // start low, data lsb first, then stops
  // second stop can be driven low on request
  // quiet time first so a false start from a low second stop has died out
  task automatic send(input logic [8:0] d, input int n, input logic s1, input logic s2,
                      input int p);
    repeat (12 * p) @(posedge aclk);
    rxd <= 1'b0;
    repeat (p) @(posedge aclk);
    for (int i = 0; i < n; i++) begin
      rxd <= d[i];
      repeat (p) @(posedge aclk);
    end
    rxd <= s1;
    repeat (p) @(posedge aclk);
    rxd <= s2;
    repeat (p) @(posedge aclk);
    rxd <= 1'b1;
  endtask
endmodule // uart_peer

// ---- logic/uart_frame_tx.sv ----
// serial frame transmitter with shared frame format and stop-bit check
`include "uart_tx_params.svh"
module uart_frame_tx (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  output logic             txd,
  output logic             txd_oe,
  input  wire logic        rxd,
  input  wire logic        xck_in,
  output logic             xck_out,
  output logic             xck_oe
);
  uart_tx_pkg::state_t q, d;

  // ************************************************************
  // helpers
  // ************************************************************
  // size decode
  function automatic logic [3:0] nbits(input logic [2:0] code);
    unique case (code)
      3'h0: nbits = 4'h5;
      3'h1: nbits = 4'h6;
      3'h2: nbits = 4'h7;
      `SIZE_NINE: nbits = 4'h9;
      default: nbits = 4'h8;
    endcase
  endfunction

  function automatic logic [8:0] mask_char(input logic [8:0] v, input logic [3:0] n);
    mask_char = v & 9'((10'h001 << n) - 10'h001);
  endfunction

  // xor of data bits, odd inverts
  function automatic logic parity_of(input logic [8:0] v, input logic odd);
    parity_of = (^v) ^ odd;
  endfunction

  // baud ticks per bit, minus one
  function automatic logic [3:0] bit_div(input logic sync, input logic u2x);
    bit_div = sync ? `DIV_SYNC : (u2x ? `DIV_DOUBLE : `DIV_NORMAL);
  endfunction

  logic [2:0] size_code;
  logic [3:0] n_bits, div;
  logic       par_en, par_odd, baud_tick, tx_tick, rx_samp, xk_rise, xk_fall, slave;
  logic       wr_go, last_stop;
  always_comb begin
    size_code = {q.size2, q.size10};
    n_bits    = nbits(size_code);
    par_en    = q.pm[1];
    par_odd   = q.pm[0];
    div       = bit_div(q.sync, q.u2x);
    slave     = q.sync & q.xck_slave;
    baud_tick = (q.baud_cnt == 12'h000);
    xk_rise   = q.xk_s2 & ~q.xk_s3;
    xk_fall   = ~q.xk_s2 & q.xk_s3;
    // slave clock edges from the pin
    tx_tick   = slave ? xk_rise : (baud_tick && q.tx_pre == div);
    rx_samp   = q.sync ? (slave ? xk_fall : (baud_tick && q.tx_pre == (div >> 1)))
                       : (baud_tick && q.rx_pre == 4'h0);
    wr_go     = q.aw_have & q.w_have & ~q.bvalid;
    last_stop = tx_tick && ((q.tx_state == uart_tx_pkg::TX_STOP1 && !q.stop2)
                            || q.tx_state == uart_tx_pkg::TX_STOP2);
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    d = q;
    d.rx_s1 = rxd;
    d.rx_s2 = q.rx_s1;
    d.xk_s1 = xck_in;
    d.xk_s2 = q.xk_s1;
    d.xk_s3 = q.xk_s2;
    d.baud_cnt = baud_tick ? q.ubrr : q.baud_cnt - 12'h001;
    if (baud_tick)
      d.tx_pre = (q.tx_pre >= div) ? 4'h0 : q.tx_pre + 4'h1;

    // bus write side; address and data taken in either order
    if (awvalid && q.awready) begin
      d.aw_have = 1'b1;
      d.awready = 1'b0;
      d.awaddr  = awaddr;
    end
    if (wvalid && q.wready) begin
      d.w_have = 1'b1;
      d.wready = 1'b0;
      d.wdata  = wdata[7:0];
      d.wstrb0 = wstrb[0];
    end
    if (q.bvalid && bready) begin
      d.bvalid  = 1'b0;
      d.awready = 1'b1;
      d.wready  = 1'b1;
    end
    if (wr_go) begin
      d.aw_have = 1'b0;
      d.w_have  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = `RESP_OKAY;
      unique case (q.awaddr)
        `OFF_DATA: begin
          if (q.wstrb0) begin
            d.buf_data = mask_char({q.ninth, q.wdata}, n_bits);
            d.buf_full = 1'b1;
          end
        end
        `OFF_CSA: begin
          if (q.wstrb0) begin
            d.u2x = q.wdata[`CSA_U2X];
            if (q.wdata[`CSA_TXC])
              d.tx_complete_flag = 1'b0;
          end
        end
        `OFF_CSB: begin
          if (q.wstrb0) begin
            d.xck_slave = q.wdata[`CSB_XCK_SLAVE];
            d.rx_on     = q.wdata[`CSB_RX_ON];
            d.tx_on     = q.wdata[`CSB_TX_ON];
            d.size2     = q.wdata[`CSB_SIZE2];
            d.ninth     = q.wdata[`CSB_NINTH];
          end
        end
        `OFF_SHARED: begin
          // select bit steers the shared location
          if (q.wstrb0 && q.wdata[`CSC_SELECT]) begin
            d.sync   = q.wdata[`CSC_SYNC];
            d.pm     = q.wdata[`CSC_PM_HI:`CSC_PM_LO];
            d.stop2  = q.wdata[`CSC_STOP];
            d.size10 = q.wdata[`CSC_SIZE_HI:`CSC_SIZE_LO];
          end else if (q.wstrb0) begin
            d.ubrr[11:8] = q.wdata[3:0];
          end
        end
        `OFF_BAUD_LO: begin
          if (q.wstrb0) begin
            d.ubrr[7:0] = q.wdata;
            d.baud_cnt  = {q.ubrr[11:8], q.wdata};
          end
        end
        default: d.bresp = `RESP_SLVERR;
      endcase
    end

    // bus read side
    if (q.rvalid && rready) begin
      d.rvalid  = 1'b0;
      d.arready = 1'b1;
    end
    if (arvalid && q.arready) begin
      d.arready = 1'b0;
      d.rvalid  = 1'b1;
      d.rresp   = `RESP_OKAY;
      d.rdata   = 32'h0000_0000;
      unique case (araddr)
        `OFF_DATA: d.rdata = 32'h0000_0000;
        `OFF_CSA: begin
          d.rdata[`CSA_TXC]  = q.tx_complete_flag;
          d.rdata[`CSA_TX_BUFFER_EMPTY_FLAG] = ~q.buf_full;
          d.rdata[`CSA_FE]   = q.fe;
          d.rdata[`CSA_U2X]  = q.u2x;
        end
        `OFF_CSB: d.rdata[7:0] = {q.xck_slave, 2'h0, q.rx_on, q.tx_on, q.size2, 1'b0, q.ninth};
        `OFF_SHARED: d.rdata[7:0] = {1'b1, q.sync, q.pm, q.stop2, q.size10, 1'b0};
        `OFF_BAUD_LO: d.rdata[7:0] = q.ubrr[7:0];
        default: d.rresp = `RESP_SLVERR;
      endcase
    end

    // ************************************************************
    // transmitter
    // ************************************************************
    if (tx_tick) begin
      unique case (q.tx_state)
        uart_tx_pkg::TX_IDLE: begin
          if (q.buf_full && q.tx_on) begin
            d.tx_state = uart_tx_pkg::TX_START;
            d.tx_shift = q.buf_data;
            d.tx_data  = q.buf_data;
            d.buf_full = 1'b0;
            d.txd      = 1'b0;
          end
        end
        uart_tx_pkg::TX_START: begin
          d.tx_state = uart_tx_pkg::TX_DATA;
          d.txd      = q.tx_shift[0];
          d.tx_shift = q.tx_shift >> 1;
          d.tx_cnt   = 4'h1;
        end
        uart_tx_pkg::TX_DATA: begin
          if (q.tx_cnt == n_bits) begin
            // parity right after last data bit
            d.tx_state = par_en ? uart_tx_pkg::TX_PARITY : uart_tx_pkg::TX_STOP1;
            d.txd      = par_en ? parity_of(q.tx_data, par_odd) : 1'b1;
          end else begin
            // ninth bit goes out as data
            d.txd      = q.tx_shift[0];
            d.tx_shift = q.tx_shift >> 1;
            d.tx_cnt   = q.tx_cnt + 4'h1;
          end
        end
        uart_tx_pkg::TX_PARITY: begin
          d.tx_state = uart_tx_pkg::TX_STOP1;
          d.txd      = 1'b1;
        end
        uart_tx_pkg::TX_STOP1: begin
          if (q.stop2) begin
            d.tx_state = uart_tx_pkg::TX_STOP2;
            d.txd      = 1'b1;
          end
        end
        uart_tx_pkg::TX_STOP2: d.txd = 1'b1;
        default: d.tx_state = uart_tx_pkg::TX_IDLE;
      endcase
      if (last_stop) begin
        if (q.buf_full && q.tx_on) begin
          d.tx_state = uart_tx_pkg::TX_START;
          d.tx_shift = q.buf_data;
          d.tx_data  = q.buf_data;
          d.buf_full = 1'b0;
          d.txd      = 1'b0;
        end else begin
          d.tx_state = uart_tx_pkg::TX_IDLE;
          d.txd      = 1'b1;
          // set wins over a clear in the same cycle
          d.tx_complete_flag      = 1'b1;
        end
      end
    end
    // a data write in the load cycle keeps the new character
    if (wr_go && q.awaddr == `OFF_DATA && q.wstrb0) begin
      d.buf_data = mask_char({q.ninth, q.wdata}, n_bits);
      d.buf_full = 1'b1;
    end
    // pin override, held until pending work drains
    d.txd_oe = q.tx_on | q.buf_full | (q.tx_state != uart_tx_pkg::TX_IDLE);
    // master drives the bit clock, slave leaves the pin as input
    d.xck_oe = q.sync & ~q.xck_slave;
    if (q.sync && !slave && baud_tick)
      d.xck_o = (q.tx_pre == div) ? 1'b1 : ((q.tx_pre == (div >> 1)) ? 1'b0 : q.xck_o);

    // ************************************************************
    // receiver stop-bit check
    // ************************************************************
    if (!q.sync && baud_tick)
      d.rx_pre = (q.rx_pre == 4'h0) ? div : q.rx_pre - 4'h1;
    if (!q.rx_on) begin
      d.rx_state = uart_tx_pkg::RX_IDLE;
    end else begin
      unique case (q.rx_state)
        uart_tx_pkg::RX_IDLE: begin
          if (!q.sync && !q.rx_s2) begin
            d.rx_state = uart_tx_pkg::RX_START;
            d.rx_pre   = div >> 1;
          end else if (q.sync && rx_samp && !q.rx_s2) begin
            d.rx_state = uart_tx_pkg::RX_DATA;
            d.rx_cnt   = 4'h0;
          end
        end
        uart_tx_pkg::RX_START: begin
          if (rx_samp) begin
            d.rx_state = q.rx_s2 ? uart_tx_pkg::RX_IDLE : uart_tx_pkg::RX_DATA;
            d.rx_cnt   = 4'h0;
          end
        end
        uart_tx_pkg::RX_DATA: begin
          if (rx_samp) begin
            d.rx_cnt = q.rx_cnt + 4'h1;
            if (q.rx_cnt + 4'h1 == n_bits)
              d.rx_state = par_en ? uart_tx_pkg::RX_PARITY : uart_tx_pkg::RX_STOP;
          end
        end
        uart_tx_pkg::RX_PARITY: begin
          if (rx_samp)
            d.rx_state = uart_tx_pkg::RX_STOP;
        end
        uart_tx_pkg::RX_STOP: begin
          if (rx_samp) begin
            // error only on a low first stop
            d.fe       = ~q.rx_s2;
            d.rx_state = uart_tx_pkg::RX_IDLE;
          end
        end
        default: d.rx_state = uart_tx_pkg::RX_IDLE;
      endcase
    end
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q          <= '0;
      q.awready  <= 1'b1;
      q.wready   <= 1'b1;
      q.arready  <= 1'b1;
      q.txd      <= 1'b1;
      q.rx_s1    <= 1'b1;
      q.rx_s2    <= 1'b1;
      q.size10   <= `SIZE_RESET;
      q.tx_state <= uart_tx_pkg::TX_IDLE;
      q.rx_state <= uart_tx_pkg::RX_IDLE;
    end else begin
      q <= d;
    end
  end

  assign awready = q.awready;
  assign wready  = q.wready;
  assign bvalid  = q.bvalid;
  assign bresp   = q.bresp;
  assign arready = q.arready;
  assign rvalid  = q.rvalid;
  assign rdata   = q.rdata;
  assign rresp   = q.rresp;
  assign txd     = q.txd;
  assign txd_oe  = q.txd_oe;
  assign xck_out = q.xck_o;
  assign xck_oe  = q.xck_oe;

  // ************************************************************
  // checks
  // ************************************************************
  sequence s_last_data;
    q.tx_state == uart_tx_pkg::TX_DATA && tx_tick && q.tx_cnt == n_bits;
  endsequence
  sequence s_frame_end;
    last_stop;
  endsequence

  property p_stop_high;
    @(posedge aclk) disable iff (!aresetn)
      (q.tx_state == uart_tx_pkg::TX_STOP1 || q.tx_state == uart_tx_pkg::TX_STOP2) |-> q.txd;
  endproperty
  a_stop_high: assert property (p_stop_high) else $error("stop bit low");
  property p_idle_high;
    @(posedge aclk) disable iff (!aresetn)
      q.tx_state == uart_tx_pkg::TX_IDLE |-> q.txd;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("idle line low");
  property p_start_low;
    @(posedge aclk) disable iff (!aresetn)
      q.tx_state == uart_tx_pkg::TX_START |-> !q.txd;
  endproperty
  a_start_low: assert property (p_start_low) else $error("start bit high");
  property p_parity_val;
    @(posedge aclk) disable iff (!aresetn)
      q.tx_state == uart_tx_pkg::TX_PARITY |-> q.txd == ((^q.tx_data) ^ q.pm[0]);
  endproperty
  a_parity_val: assert property (p_parity_val) else $error("parity wrong");
  property p_parity_place;
    @(posedge aclk) disable iff (!aresetn)
      s_last_data ##0 par_en |=> q.tx_state == uart_tx_pkg::TX_PARITY;
  endproperty
  a_parity_place: assert property (p_parity_place) else $error("parity misplaced");
  property p_reload;
    @(posedge aclk) disable iff (!aresetn)
      s_frame_end ##0 (q.buf_full && q.tx_on) |=> q.tx_state == uart_tx_pkg::TX_START && !q.txd;
  endproperty
  a_reload: assert property (p_reload) else $error("no reload after stop");
  property p_txc_set;
    @(posedge aclk) disable iff (!aresetn)
      s_frame_end ##0 !q.buf_full |=> q.tx_complete_flag ##1 (q.tx_complete_flag || $past(wr_go));
  endproperty
  a_txc_set: assert property (p_txc_set) else $error("complete flag not set");
  property p_buf_load;
    @(posedge aclk) disable iff (!aresetn)
      wr_go && q.awaddr == `OFF_DATA && q.wstrb0 |=> q.buf_full;
  endproperty
  a_buf_load: assert property (p_buf_load) else $error("buffer not loaded");
  property p_fe;
    @(posedge aclk) disable iff (!aresetn)
      q.rx_on && q.rx_state == uart_tx_pkg::RX_STOP && rx_samp |=> q.fe == !$past(q.rx_s2);
  endproperty
  a_fe: assert property (p_fe) else $error("frame error wrong");
  property p_pin_take;
    @(posedge aclk) disable iff (!aresetn)
      q.tx_on |=> q.txd_oe;
  endproperty
  a_pin_take: assert property (p_pin_take) else $error("pin not taken");
endmodule // uart_frame_tx

// ---- logic/uart_tx_params.svh ----
// constants for the serial frame transmitter block
`ifndef UART_TX_PARAMS_SVH
`define UART_TX_PARAMS_SVH
// register byte offsets
`define OFF_DATA      8'h00
`define OFF_CSA       8'h04
`define OFF_CSB       8'h08
`define OFF_SHARED    8'h0c
`define OFF_BAUD_LO   8'h10
// ctrl_status_a bits
`define CSA_TXC       6
`define CSA_TX_BUFFER_EMPTY_FLAG      5
`define CSA_FE        4
`define CSA_U2X       1
// ctrl_status_b bits
`define CSB_XCK_SLAVE 7
`define CSB_RX_ON     4
`define CSB_TX_ON     3
`define CSB_SIZE2     2
`define CSB_NINTH     0
// ctrl_status_c bits, valid when select bit set
`define CSC_SELECT    7
`define CSC_SYNC      6
`define CSC_PM_HI     5
`define CSC_PM_LO     4
`define CSC_STOP      3
`define CSC_SIZE_HI   2
`define CSC_SIZE_LO   1
// codes and counts
`define SIZE_NINE     3'h7
`define PM_OFF        2'h0
`define DIV_NORMAL    4'hf
`define DIV_DOUBLE    4'h7
`define DIV_SYNC      4'h1
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2
`define SIZE_RESET    2'h3
`endif

// ---- logic/uart_tx_pkg.sv ----
// state types of the serial frame transmitter block
package uart_tx_pkg;
  typedef enum logic [2:0] {
    TX_IDLE   = 3'b000,
    TX_START  = 3'b001,
    TX_DATA   = 3'b010,
    TX_PARITY = 3'b011,
    TX_STOP1  = 3'b100,
    TX_STOP2  = 3'b101
  } tx_state_t;
  typedef enum logic [2:0] {
    RX_IDLE   = 3'b000,
    RX_START  = 3'b001,
    RX_DATA   = 3'b010,
    RX_PARITY = 3'b011,
    RX_STOP   = 3'b100
  } rx_state_t;
  typedef struct packed {
    logic aw_have, w_have, awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr, wdata;
    logic wstrb0;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic u2x, tx_complete_flag, fe, rx_on, tx_on, size2, ninth, sync, xck_slave, stop2;
    logic [1:0] pm, size10;
    logic [11:0] ubrr, baud_cnt;
    logic [3:0] tx_pre, tx_cnt, rx_pre, rx_cnt;
    logic [8:0] buf_data, tx_shift, tx_data;
    logic buf_full, txd, txd_oe, xck_o, xck_oe;
    tx_state_t tx_state;
    rx_state_t rx_state;
    logic rx_s1, rx_s2, xk_s1, xk_s2, xk_s3;
  } state_t;
endpackage
